// ===== apcsc_ctrl.sv
// Purpose: Clock mode, power-down and serial control of a 12-bit SAR converter
// Assumes: Serial clock, select, data and shutdown pins are asynchronous
// Notes:   Comparator input answers "input >= o_dac_code"
`timescale 1ns/1ps

// Notes on behaviour
// (RULE1) Mode bits: 11 ext, 10 int, 00 down
// (RULE2) Shutdown high slow clock, open fast, low down
// (RULE3) Software power-down waits for conversion end
// (RULE4) Internal mode: readout works while powered down
// (RULE5) First one bit starts and wakes device
// (RULE6) High mode bit stays up; 00 sleeps after
// (RULE7) Shutdown low aborts conversion at once
// (RULE8) Straight binary 12-bit result codes
// (RULE9) Host uses clock polarity and phase zero
// (RULE10) Host keeps serial clock at most 1.5MHz; host model drives about 15.4MHz (13 ref cycles)
// (RULE11) Host may sequence all eight channels
// (RULE12) Processor host clocks active high, tied
// (RULE13) Bits accepted only with select low
// (RULE14) External start word is 1xxxxx11
// (RULE15) Strobe falling marks conversion under way
// (RULE16) Host samples 16 bits, 12 result first
// (RULE17) Host raises select after reading result
// (RULE18) Shutdown low overrides control byte bits
// (RULE19) Result shifted on falling edges, MSB first
// (RULE20) Ext mode strobe high one period after byte
// (RULE21) First high bit is control byte bit one
// (RULE22) Unassigned code keeps previous mode and power
module apcsc_ctrl #(
	parameter int RES_BITS   = apcsc_pkg::RES_BITS,
	parameter int FIFO_DEPTH = apcsc_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                i_ref_clk,
	input  wire logic                i_rst_n,
	// Serial link pins
	input  wire logic                i_sclk,
	input  wire logic                i_cs_n,
	input  wire logic                i_din,
	output logic                     o_dout,
	output logic                     o_dout_oe_n,
	output logic                     o_conversion_strobe,
	output logic                     o_conversion_strobe_oe_n,
	// Shutdown pin, sensed as driven low or left open
	input  wire logic                i_shutdown_pin_low,
	input  wire logic                i_shutdown_pin_open,
	// Analog side
	input  wire logic                i_cmp_high,
	output logic [RES_BITS-1:0]      o_dac_code,
	// Status
	output logic                     o_powered,
	output logic                     o_ext_clk_mode,
	output logic                     o_int_clk_fast
);
	initial begin
		if (RES_BITS != apcsc_pkg::RES_BITS || FIFO_DEPTH < 2)
			$error("apcsc_ctrl: unsupported RES_BITS or FIFO_DEPTH");
	end

	typedef enum {ST_IDLE, ST_CTRL, ST_EXT_STROBE, ST_EXT_CONV, ST_INT_CONV, ST_INT_PUSH} apcsc_state_t;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic sclk_m_q, sclk_s_q, sclk_d_q, cs_m_q, cs_s_q, din_m_q, din_s_q;
	logic shl_m_q, shl_s_q, sho_m_q, sho_s_q, cmp_m_q, cmp_s_q;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{sclk_m_q, sclk_s_q, sclk_d_q} <= 3'h0;
			{cs_m_q, cs_s_q}               <= 2'h3;
			{din_m_q, din_s_q}             <= 2'h0;
			{shl_m_q, shl_s_q}             <= 2'h0;
			{sho_m_q, sho_s_q}             <= 2'h0;
			{cmp_m_q, cmp_s_q}             <= 2'h0;
		end else begin
			{sclk_m_q, sclk_s_q, sclk_d_q} <= {i_sclk, sclk_m_q, sclk_s_q};
			{cs_m_q, cs_s_q}               <= {i_cs_n, cs_m_q};
			{din_m_q, din_s_q}             <= {i_din, din_m_q};
			{shl_m_q, shl_s_q}             <= {i_shutdown_pin_low, shl_m_q};
			{sho_m_q, sho_s_q}             <= {i_shutdown_pin_open, sho_m_q};
			{cmp_m_q, cmp_s_q}             <= {i_cmp_high, cmp_m_q};
		end
	end

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic apcsc_pkg::apcsc_clk_mode_t next_mode(input logic [1:0] code,
		input apcsc_pkg::apcsc_clk_mode_t cur);
		if (code == apcsc_pkg::MODE_EXT_CLK)
			next_mode = apcsc_pkg::APCSC_CLK_EXT;
		else if (code == apcsc_pkg::MODE_INT_CLK)
			next_mode = apcsc_pkg::APCSC_CLK_INT;
		else
			next_mode = cur;
	endfunction

	function automatic logic [RES_BITS-1:0] bit_at(input logic [3:0] idx, input logic val);
		bit_at = '0;
		bit_at[idx] = val;
	endfunction

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	apcsc_state_t                state_q;
	apcsc_pkg::apcsc_clk_mode_t  clk_mode_q;
	logic [apcsc_pkg::CTRL_BITS-1:0] ctrl_q;
	logic [2:0]                  bit_cnt_q;
	logic [3:0]                  step_q;
	logic [RES_BITS-1:0]         sar_q;
	logic                        powered_q;
	logic                        pd_after_q;
	logic                        strobe_q;
	logic [apcsc_pkg::DIV_BITS-1:0] div_q;
	logic                        fast_q;
	logic [apcsc_pkg::OUT_BITS-1:0] out_q;
	logic [4:0]                  out_cnt_q;

	apcsc_stream_if #(.WIDTH(RES_BITS)) res_if ();

	wire       sclk_rise  = sclk_s_q & ~sclk_d_q;
	wire       sclk_fall  = ~sclk_s_q & sclk_d_q;
	wire       sel        = ~cs_s_q;
	wire       rise_sel   = sclk_rise & sel;                                    // see (RULE13)
	wire       fall_sel   = sclk_fall & sel;
	wire       start_bit  = (state_q == ST_IDLE) & rise_sel & din_s_q;          // see (RULE5) see (RULE21)
	wire [7:0] ctrl_next  = {ctrl_q[6:0], din_s_q};
	wire [1:0] mode_code  = {ctrl_next[apcsc_pkg::PD_HIGH_POS], ctrl_next[apcsc_pkg::PD_LOW_POS]};
	wire       ctrl_last  = (state_q == ST_CTRL) & rise_sel & (bit_cnt_q == 3'(apcsc_pkg::CTRL_BITS - 1));
	wire       new_ext    = next_mode(mode_code, clk_mode_q) == apcsc_pkg::APCSC_CLK_EXT; // see (RULE1) see (RULE22)
	wire       step_last  = (step_q == 4'h0);
	wire       div_tick   = (div_q == '0);
	wire       ext_step   = (state_q == ST_EXT_CONV) & fall_sel;
	wire       int_step   = (state_q == ST_INT_CONV) & div_tick;
	wire       conv_done  = (ext_step & step_last) | ((state_q == ST_INT_PUSH) & res_if.wr_ready);
	wire [RES_BITS-1:0] sar_new = sar_q | bit_at(step_q, cmp_s_q);             // see (RULE8)
	wire       load_out   = (out_cnt_q == 5'h0) & res_if.rd_valid;

	assign res_if.wr_valid = (state_q == ST_INT_PUSH);
	assign res_if.wr_data  = sar_q;
	assign res_if.rd_ready = (out_cnt_q == 5'h0);

	apcsc_fifo #(.WIDTH(RES_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.s         (res_if.fifo)
	);

	// ------------------------------------------------------------
	// Internal conversion clock divider
	// ------------------------------------------------------------
	wire [apcsc_pkg::DIV_BITS-1:0] div_load = fast_q ?
		apcsc_pkg::DIV_BITS'(apcsc_pkg::INT_FAST_DIV - 1) : apcsc_pkg::DIV_BITS'(apcsc_pkg::INT_SLOW_DIV - 1);

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_q  <= '0;
			fast_q <= 1'b0;
		end else begin
			fast_q <= sho_s_q;                                                 // see (RULE2)
			div_q  <= div_tick ? div_load : div_q - 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Control state machine
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q    <= ST_IDLE;
			clk_mode_q <= apcsc_pkg::APCSC_CLK_INT;
			ctrl_q     <= '0;
			bit_cnt_q  <= '0;
			step_q     <= '0;
			sar_q      <= '0;
			powered_q  <= 1'b1;
			pd_after_q <= 1'b0;
			strobe_q   <= 1'b1;
		end else if (shl_s_q) begin
			state_q    <= ST_IDLE;                                             // see (RULE7) see (RULE18)
			powered_q  <= 1'b0;
			pd_after_q <= 1'b0;
		end else begin
			if (conv_done && pd_after_q)
				powered_q <= 1'b0;                                             // see (RULE3) see (RULE6)
			case (state_q)
				ST_IDLE: begin
					if (start_bit) begin
						state_q   <= ST_CTRL;
						ctrl_q    <= 8'h01;
						bit_cnt_q <= 3'h1;
						powered_q <= 1'b1;                                     // see (RULE5)
					end
				end
				ST_CTRL: begin
					if (!sel) begin
						state_q <= ST_IDLE;
					end else if (rise_sel) begin
						ctrl_q    <= ctrl_next;
						bit_cnt_q <= bit_cnt_q + 3'h1;
						if (ctrl_last) begin
							clk_mode_q <= next_mode(mode_code, clk_mode_q);   // see (RULE1) see (RULE22)
							if (mode_code != apcsc_pkg::MODE_UNUSED)
								pd_after_q <= (mode_code == apcsc_pkg::MODE_PWR_DN); // see (RULE6)
							sar_q  <= '0;
							step_q <= 4'(RES_BITS - 1);
							if (new_ext) begin
								state_q <= ST_EXT_STROBE;
							end else begin
								state_q  <= ST_INT_CONV;
								strobe_q <= 1'b0;                              // see (RULE15)
							end
						end
					end
				end
				ST_EXT_STROBE: begin
					if (!sel) begin
						state_q <= ST_IDLE;
					end else if (sclk_fall) begin
						strobe_q <= 1'b1;                                      // see (RULE20)
						state_q  <= ST_EXT_CONV;
					end
				end
				ST_EXT_CONV: begin
					if (!sel) begin
						state_q  <= ST_IDLE;
						strobe_q <= 1'b0;
					end else if (ext_step) begin
						strobe_q <= 1'b0;                                      // see (RULE15)
						sar_q    <= sar_new;
						step_q   <= step_q - 4'h1;
						if (step_last)
							state_q <= ST_IDLE;
					end
				end
				ST_INT_CONV: begin
					if (int_step) begin
						sar_q  <= sar_new;
						step_q <= step_q - 4'h1;
						if (step_last)
							state_q <= ST_INT_PUSH;
					end
				end
				ST_INT_PUSH: begin
					if (res_if.wr_ready) begin
						strobe_q <= 1'b1;
						state_q  <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Result shifter, runs regardless of power state
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_q     <= '0;
			out_cnt_q <= '0;
		end else if (load_out) begin
			out_q     <= {res_if.rd_data, 4'h0};                               // see (RULE4)
			out_cnt_q <= 5'(apcsc_pkg::OUT_BITS);
		end else if (fall_sel && out_cnt_q != 5'h0 && state_q != ST_EXT_CONV) begin
			out_q     <= {out_q[apcsc_pkg::OUT_BITS-2:0], 1'b0};
			out_cnt_q <= out_cnt_q - 5'h1;
		end
	end

	// ------------------------------------------------------------
	// Pin outputs
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_dout                   <= 1'b0;
			o_dout_oe_n              <= 1'b1;
			o_conversion_strobe      <= 1'b1;
			o_conversion_strobe_oe_n <= 1'b0;
			o_dac_code               <= '0;
			o_powered                <= 1'b1;
			o_ext_clk_mode           <= 1'b0;
			o_int_clk_fast           <= 1'b0;
		end else begin
			if (fall_sel)
				o_dout <= ext_step ? cmp_s_q : (out_cnt_q != 5'h0) & out_q[apcsc_pkg::OUT_BITS-1]; // see (RULE19)
			o_dout_oe_n              <= cs_s_q;
			o_conversion_strobe      <= strobe_q;
			o_conversion_strobe_oe_n <= cs_s_q & (clk_mode_q == apcsc_pkg::APCSC_CLK_EXT);
			o_dac_code               <= sar_q | bit_at(step_q, 1'b1);
			o_powered                <= powered_q;
			o_ext_clk_mode           <= (clk_mode_q == apcsc_pkg::APCSC_CLK_EXT);
			o_int_clk_fast           <= fast_q;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_ctrl_byte_done;
		!shl_s_q && ctrl_last;
	endsequence

	sequence s_ext_strobe_edge;
		!shl_s_q && state_q == ST_EXT_STROBE && sel && sclk_fall;
	endsequence

	a_ext_mode_decode: assert property (s_ctrl_byte_done ##0 mode_code == apcsc_pkg::MODE_EXT_CLK // see (RULE1)
		|=> clk_mode_q == apcsc_pkg::APCSC_CLK_EXT && state_q == ST_EXT_STROBE)
		else $error("external mode code not decoded");
	a_int_mode_decode: assert property (s_ctrl_byte_done ##0 mode_code == apcsc_pkg::MODE_INT_CLK // see (RULE1)
		|=> clk_mode_q == apcsc_pkg::APCSC_CLK_INT && state_q == ST_INT_CONV && !strobe_q)
		else $error("internal mode code not decoded");
	a_unassigned_keeps: assert property (s_ctrl_byte_done ##0 mode_code == apcsc_pkg::MODE_UNUSED // see (RULE22)
		|=> $stable(clk_mode_q) && $stable(pd_after_q))
		else $error("unassigned code changed mode");
	a_shutdown_pin_rate_sel: assert property (sho_s_q |-> ##2 o_int_clk_fast) // see (RULE2)
		else $error("open shutdown pin did not select fast clock");
	a_shutdown_pin_abort_now: assert property (shl_s_q |=> state_q == ST_IDLE && !powered_q ##1 !o_powered) // see (RULE7)
		else $error("shutdown did not abort");
	a_pd_after_conv: assert property (!shl_s_q && conv_done && pd_after_q |=> !powered_q) // see (RULE3)
		else $error("no power-down after conversion");
	a_start_wakes: assert property (!shl_s_q && start_bit |=> powered_q && state_q == ST_CTRL) // see (RULE5)
		else $error("start bit did not wake device");
	a_ext_strobe_one: assert property (s_ext_strobe_edge |=> strobe_q && state_q == ST_EXT_CONV) // see (RULE20)
		else $error("strobe not raised after control byte");
	a_ext_strobe_drop: assert property (!shl_s_q && ext_step && step_q == 4'(RES_BITS - 1) |=> !strobe_q) // see (RULE15)
		else $error("strobe not lowered at first decision");
	a_dout_msb_first: assert property (fall_sel && out_cnt_q == 5'(apcsc_pkg::OUT_BITS) && state_q != ST_EXT_CONV // see (RULE19)
		|=> o_dout == $past(out_q[apcsc_pkg::OUT_BITS-1])) else $error("result MSB not shifted first");

endmodule // apcsc_ctrl

// ===== apcsc_pkg.sv
// Purpose: Shared constants for the converter mode and serial control block
// Assumes: 200 MHz reference clock
// Notes:   Mode codes are the two low bits of the control byte
package apcsc_pkg;

	// ------------------------------------------------------------
	// Widths and field positions
	// ------------------------------------------------------------
	localparam int RES_BITS     = 12;
	localparam int CTRL_BITS    = 8;
	localparam int OUT_BITS     = 16;
	localparam int FIFO_DEPTH   = 16;
	localparam int PD_HIGH_POS  = 1;
	localparam int PD_LOW_POS   = 0;

	// ------------------------------------------------------------
	// Power mode codes {power_mode_high_bit, power_mode_low_bit}
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_EXT_CLK = 2'h3;
	localparam logic [1:0] MODE_INT_CLK = 2'h2;
	localparam logic [1:0] MODE_UNUSED  = 2'h1;
	localparam logic [1:0] MODE_PWR_DN  = 2'h0;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int REF_CLK_HZ   = 200_000_000;
	localparam int INT_SLOW_HZ  = 225_000;
	localparam int INT_FAST_HZ  = 1_500_000;
	localparam int INT_SLOW_DIV = REF_CLK_HZ / INT_SLOW_HZ;
	localparam int INT_FAST_DIV = REF_CLK_HZ / INT_FAST_HZ;
	localparam int DIV_BITS     = 10;

	typedef enum logic {APCSC_CLK_EXT, APCSC_CLK_INT} apcsc_clk_mode_t;

endpackage

// ===== apcsc_stream_if.sv
// Purpose: Result word stream between the converter core and its FIFO
// Assumes: Single clock domain
// Notes:   Valid and ready on both sides
`timescale 1ns/1ps
interface apcsc_stream_if #(parameter int WIDTH = 12);
	logic             wr_valid;
	logic             wr_ready;
	logic [WIDTH-1:0] wr_data;
	logic             rd_valid;
	logic             rd_ready;
	logic [WIDTH-1:0] rd_data;

	modport fifo (input wr_valid, input wr_data, input rd_ready,
		output wr_ready, output rd_valid, output rd_data);
	modport user (output wr_valid, output wr_data, output rd_ready,
		input wr_ready, input rd_valid, input rd_data);
endinterface

// ===== apcsc_fifo.sv
// Purpose: Result FIFO for internal clock mode conversions
// Assumes: DEPTH is a power of two
// Notes:   Full stalls the converter; empty stalls the shifter
`timescale 1ns/1ps
module apcsc_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic   i_ref_clk,
	input  wire logic   i_rst_n,
	// Stream
	apcsc_stream_if.fifo s
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
			$error("apcsc_fifo: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      count_q;
	wire              do_wr = s.wr_valid & s.wr_ready;
	wire              do_rd = s.rd_valid & s.rd_ready;

	assign s.wr_ready = (count_q != (AW+1)'(DEPTH));
	assign s.rd_valid = (count_q != '0);
	assign s.rd_data  = mem[rd_ptr_q];

	always_ff @(posedge i_ref_clk) begin
		if (do_wr)
			mem[wr_ptr_q] <= s.wr_data;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (do_wr)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (do_rd)
				rd_ptr_q <= rd_ptr_q + 1'b1;
			count_q <= count_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule // apcsc_fifo

// ===== apcsc_host_model.sv
// Purpose: Host serial master model facing apcsc_ctrl
// Assumes: Clock polarity and phase zero, link period near 65 ns
// Notes:   Tasks start on a rising i_ref_clk edge and drive by non-blocking assignment
`timescale 1ns/1ps
module apcsc_host_model (
	// Clock
	input  wire logic i_ref_clk,
	// Link pins
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic      o_din,
	input  wire logic i_dout,
	input  wire logic i_dout_oe_n
);
	// ------------------------------------------------------------
	// Line level and link tasks
	// ------------------------------------------------------------
	logic last_q;
	logic dout_w;

	// Released data line shows the inverse of its last driven value
	assign dout_w = i_dout_oe_n ? ~last_q : i_dout;

	initial begin
		o_sclk = 1'h0;
		o_cs_n = 1'h1;
		o_din  = 1'h0;
		last_q = 1'h0;
	end

	always @(posedge i_ref_clk) begin
		if (!i_dout_oe_n) begin
			last_q <= i_dout;
		end
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask

	task automatic set_cs(input logic v);
		o_cs_n <= v;
		wait_clk(4);
	endtask

	// One link period of 13 ref cycles; clock idles low between frames
	task automatic clk_bit(input logic b, output logic s);
		o_din <= b;
		wait_clk(6);
		o_sclk <= 1'h1;
		s = dout_w;
		wait_clk(7);
		o_sclk <= 1'h0;
	endtask

	task automatic send_byte(input logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(b[i], s);
		end
	endtask

	// First edge launches the top bit, then one bit per rising edge
	task automatic read_bits(input int n, output logic [15:0] w);
		logic s;
		clk_bit(1'h0, s);
		w = 16'h0000;
		for (int i = 0; i < n; i++) begin
			clk_bit(1'h0, s);
			w = {w[14:0], s};
		end
	endtask
endmodule // apcsc_host_model

// ===== apcsc_ctrl_test.sv
// Purpose: Self-checking bench for apcsc_ctrl
// Assumes: Comparator modelled from a digital input value
// Notes:   Scenarios run in order; each leaves select high
`timescale 1ns/1ps
module apcsc_ctrl_test;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic        ref_clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        sclk;
	logic        cs_n;
	logic        din;
	logic        dout;
	logic        dout_oe_n;
	logic        strobe;
	logic        strobe_oe_n;
	logic        sd_low = 1'h0;
	logic        sd_open = 1'h1;
	logic        cmp_high = 1'h0;
	logic [11:0] dac;
	logic [11:0] ain = 12'h000;
	logic        powered;
	logic        ext_mode;
	logic        int_fast;
	logic [15:0] w;
	int          n;
	int          miscompares = 0;
	int          total_checks = 0;
	int          cycles = 0;

	always #2.5 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cmp_high <= (ain >= dac);
	end

	apcsc_ctrl i_apcsc_ctrl (
		.i_ref_clk                (ref_clk),
		.i_rst_n                  (rst_n),
		.i_sclk                   (sclk),
		.i_cs_n                   (cs_n),
		.i_din                    (din),
		.o_dout                   (dout),
		.o_dout_oe_n              (dout_oe_n),
		.o_conversion_strobe      (strobe),
		.o_conversion_strobe_oe_n (strobe_oe_n),
		.i_shutdown_pin_low       (sd_low),
		.i_shutdown_pin_open      (sd_open),
		.i_cmp_high               (cmp_high),
		.o_dac_code               (dac),
		.o_powered                (powered),
		.o_ext_clk_mode           (ext_mode),
		.o_int_clk_fast           (int_fast)
	);

	apcsc_host_model i_apcsc_host_model (
		.i_ref_clk   (ref_clk),
		.o_sclk      (sclk),
		.o_cs_n      (cs_n),
		.o_din       (din),
		.i_dout      (dout),
		.i_dout_oe_n (dout_oe_n)
	);

	// ------------------------------------------------------------
	// Checking and helpers
	// ------------------------------------------------------------
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			miscompares = miscompares + 1;
			summarize();
		end
	end

	task automatic chk_flag(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wait_clk(input int k);
		repeat (k) @(posedge ref_clk);
	endtask

	task automatic wait_strobe(input logic v, output int k);
		k = 0;
		while (strobe !== v && k < 12000) begin
			@(posedge ref_clk);
			k++;
		end
		chk_flag(strobe, v);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_ext(input logic [7:0] ctl, input logic [11:0] a);
		ain = a;
		i_apcsc_host_model.set_cs(1'h0);
		chk_flag(strobe_oe_n, 1'h0);
		i_apcsc_host_model.send_byte(ctl);
		wait_clk(5);
		chk_flag(strobe, 1'h1);
		chk_flag(ext_mode, 1'h1);
		chk_flag(powered, 1'h1);
		i_apcsc_host_model.read_bits(12, w);
		chk_word(w, {4'h0, a});
		i_apcsc_host_model.set_cs(1'h1);
		chk_flag(strobe_oe_n, 1'h1);
	endtask

	// Successive conversions across all channel codes
	task automatic t_seq();
		for (int ch = 0; ch < 8; ch++) begin
			t_ext({1'h1, 3'(ch), 4'h3}, 12'(ch * 12'h201));
		end
	endtask

	task automatic t_int(input logic [11:0] a, input logic fast);
		int tick;
		tick = fast ? apcsc_pkg::INT_FAST_DIV : apcsc_pkg::INT_SLOW_DIV;
		sd_open <= fast;
		ain = a;
		wait_clk(8);
		chk_flag(int_fast, fast);
		i_apcsc_host_model.set_cs(1'h0);
		i_apcsc_host_model.send_byte(8'h82);
		wait_clk(6);
		chk_flag(strobe, 1'h0);
		wait_strobe(1'h1, n);
		chk_flag(n > 11 * tick - 8, 1'h1);
		chk_flag(n < 13 * tick, 1'h1);
		chk_flag(ext_mode, 1'h0);
		i_apcsc_host_model.read_bits(16, w);
		chk_word(w, {a, 4'h0});
		i_apcsc_host_model.set_cs(1'h1);
		chk_flag(strobe_oe_n, 1'h0);
	endtask

	task automatic t_pwr_down();
		ain = 12'h7E1;
		i_apcsc_host_model.set_cs(1'h0);
		i_apcsc_host_model.send_byte(8'h80);
		wait_clk(6);
		chk_flag(powered, 1'h1);
		wait_strobe(1'h1, n);
		wait_clk(4);
		chk_flag(powered, 1'h0);
		i_apcsc_host_model.read_bits(16, w);
		chk_word(w, 16'h7E10);
		ain = 12'h2C7;
		i_apcsc_host_model.send_byte(8'h82);
		wait_clk(6);
		chk_flag(powered, 1'h1);
		wait_strobe(1'h1, n);
		i_apcsc_host_model.read_bits(16, w);
		chk_word(w, 16'h2C70);
		chk_flag(powered, 1'h1);
		i_apcsc_host_model.set_cs(1'h1);
	endtask

	task automatic t_shutdown();
		i_apcsc_host_model.set_cs(1'h0);
		i_apcsc_host_model.send_byte(8'h82);
		i_apcsc_host_model.set_cs(1'h1);
		wait_clk(20);
		sd_low <= 1'h1;
		wait_clk(6);
		chk_flag(powered, 1'h0);
		wait_clk(13 * apcsc_pkg::INT_FAST_DIV);
		chk_flag(strobe, 1'h0);
		i_apcsc_host_model.set_cs(1'h0);
		i_apcsc_host_model.send_byte(8'h83);
		wait_clk(6);
		chk_flag(powered, 1'h0);
		i_apcsc_host_model.set_cs(1'h1);
		sd_low <= 1'h0;
		wait_clk(8);
	endtask

	initial begin
		wait_clk(16);
		chk_flag(powered, 1'h1);
		chk_flag(ext_mode, 1'h0);
		chk_flag(strobe, 1'h1);
		chk_flag(dout_oe_n, 1'h1);
		chk_flag(dout, 1'h0);
		chk_flag(strobe_oe_n, 1'h0);
		chk_flag(int_fast, 1'h0);
		chk_word({4'h0, dac}, 16'h0000);
		rst_n <= 1'h1;
		wait_clk(8);
		t_ext(8'h83, 12'hA5C);
		t_ext(8'h81, 12'h5A3);
		t_seq();
		t_int(12'h3F1, 1'h1);
		t_int(12'hC0E, 1'h0);
		t_pwr_down();
		t_shutdown();
		summarize();
	end
endmodule // apcsc_ctrl_test
